// File: rtl/pds_top.sv
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// [R1] Standby pin low forces hardware standby immediately from any state, halting everything.
// [R2] In hardware standby every module except RAM is held in reset.
// [R3] In hardware standby all I/O port pins go high impedance.
// [R4] Software clears the RAM enable bit before the standby pin falls.
// [R5] Board holds the mode pins steady throughout hardware standby.
// [R6] Standby pin rising while reset pin low restarts the oscillator.
// [R7] Board keeps reset pin low until the oscillator has settled.
// [R8] Reset pin rising after standby exit runs reset handling, then program execution.
// [R9] Board drives reset low before driving the standby pin low.
// [R10] Board raises standby first, waits for clock, then releases reset.
// [R11] Three high and eight low stop bits each halt one supporting module.
// [R12] Writing a stop bit to 1 halts the module from the next cycle.
// [R13] Reads of a halted module return ff.
// [R14] Writes to a halted module are dropped.
// [R15] A halted module has all its registers reset, interrupt flags included.
// [R16] Software disables module interrupts before setting its stop bit.
// [R17] Pins of a halted module fall back to port behaviour.
// [R18] Software clears the stop bit, then reprograms the module.
// [R19] Clock-out stop bit at 1 puts the clock pin in high impedance.
// [R20] Clock-out stop bit at 0 drives the clock in normal and sleep modes.
// [R21] With it at 0, clock pin high in software standby, floating in hardware standby.
module pds_top #(
  parameter int NUM_MODULES = pds_pkg::NUM_MODULES
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  // Register port
  input wire logic [pds_pkg::ADDR_W-1:0] REG_ADDR_I,
  input wire logic [pds_pkg::DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [pds_pkg::DATA_W-1:0] REG_RDATA_O,
  // Board pins
  input wire logic HW_STANDBY_PIN_N_I,
  input wire logic CHIP_RESET_PIN_N_I,
  input wire logic [pds_pkg::MODE_W-1:0] OPERATING_MODE_PINS_I,
  // Operating state from the CPU
  input wire logic SW_STANDBY_I,
  input wire logic SLEEP_I,
  // Core control
  output logic HW_STANDBY_O,
  output logic CPU_HALT_O,
  output logic OSC_RUN_O,
  output logic RESET_EXC_O,
  output logic PROGRAM_RUN_O,
  output logic RAM_ENABLE_O,
  output logic PORT_HIZ_O,
  output logic [pds_pkg::MODE_W-1:0] MODE_O,
  // Supporting modules
  output logic [NUM_MODULES-1:0] MODULE_RESET_O,
  output logic [NUM_MODULES-1:0] MODULE_PIN_FUNC_EN_O,
  input wire pds_pkg::pds_per_req_t PER_REQ_I,
  input wire logic [pds_pkg::DATA_W-1:0] PER_RDATA_I,
  output logic PER_WR_O,
  output logic PER_RD_O,
  output logic [pds_pkg::DATA_W-1:0] PER_RDATA_O,
  // System clock pin
  output logic SYS_CLK_PIN_O,
  output logic SYS_CLK_PIN_OE_N_O
);

  pds_pkg::pds_state_t state_reg;
  pds_pkg::pds_state_t state_next;
  pds_pkg::pds_ctrl_t ctrl_reg;
  pds_pkg::pds_ctrl_t ctrl_next;
  logic [pds_pkg::DATA_W-1:0] rdata_reg;
  logic [pds_pkg::DATA_W-1:0] rdata_next;
  logic [pds_pkg::DATA_W-1:0] per_rdata_reg;
  logic [pds_pkg::DATA_W-1:0] per_rdata_next;
  logic [pds_pkg::MODE_W-1:0] mode_reg;
  logic clk_phase_reg;

  wire standby_pin_low = ~HW_STANDBY_PIN_N_I;
  wire hw_standby = standby_pin_low | (state_reg == pds_pkg::ST_HW_STANDBY); // [R1]
  wire ctrl_rst = RESET_I | hw_standby; // [R2]
  wire wr_sys = REG_WR_I & (REG_ADDR_I == pds_pkg::SYSTEM_CONTROL_REG_ADDR);
  wire wr_high = REG_WR_I & (REG_ADDR_I == pds_pkg::MODULE_STOP_CTRL_HIGH_ADDR);
  wire wr_low = REG_WR_I & (REG_ADDR_I == pds_pkg::MODULE_STOP_CTRL_LOW_ADDR);
  wire [NUM_MODULES-1:0] stop_vec = {ctrl_reg.high_module_stop_bits,
                                     ctrl_reg.low_module_stop_bits}; // [R11]
  wire sel_valid = PER_REQ_I.sel < pds_pkg::SEL_W'(NUM_MODULES);
  wire sel_stopped = sel_valid & stop_vec[PER_REQ_I.sel];
  wire [pds_pkg::DATA_W-1:0] sys_rd = {{(pds_pkg::DATA_W-1){1'b0}}, ctrl_reg.ram_enable_bit};
  wire [pds_pkg::DATA_W-1:0] high_rd = {ctrl_reg.clock_out_stop_bit, 4'h0,
                                        ctrl_reg.high_module_stop_bits};
  wire [pds_pkg::DATA_W-1:0] stat_rd = {4'h0, PROGRAM_RUN_O, OSC_RUN_O, hw_standby,
                                        CHIP_RESET_PIN_N_I};

  // State sequencing against the two pins
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pds_pkg::ST_RUN: begin
        if (standby_pin_low) begin
          state_next = pds_pkg::ST_HW_STANDBY; // [R1]
        end
      end
      pds_pkg::ST_HW_STANDBY: begin
        // A board that lets reset rise with standby still waits here for reset low
        if (!standby_pin_low && !CHIP_RESET_PIN_N_I) begin
          state_next = pds_pkg::ST_OSC_WAIT; // [R6]
        end
      end
      pds_pkg::ST_OSC_WAIT: begin
        if (standby_pin_low) begin
          state_next = pds_pkg::ST_HW_STANDBY; // [R1]
        end else if (CHIP_RESET_PIN_N_I) begin
          state_next = pds_pkg::ST_RST_EXC; // [R8]
        end
      end
      pds_pkg::ST_RST_EXC: begin
        state_next = standby_pin_low ? pds_pkg::ST_HW_STANDBY : pds_pkg::ST_RUN; // [R8]
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      state_reg <= pds_pkg::ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Control registers; hardware standby returns them to reset values
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_sys) begin
      ctrl_next.ram_enable_bit = REG_WDATA_I[pds_pkg::RAM_ENABLE_BIT_POS];
    end
    if (wr_high) begin
      ctrl_next.clock_out_stop_bit = REG_WDATA_I[pds_pkg::CLOCK_OUT_STOP_BIT_POS];
      ctrl_next.high_module_stop_bits = REG_WDATA_I[pds_pkg::NUM_HIGH_STOP-1:0]; // [R11]
    end
    if (wr_low) begin
      ctrl_next.low_module_stop_bits = REG_WDATA_I; // [R11]
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (ctrl_rst) begin
      ctrl_reg.ram_enable_bit <= pds_pkg::RAM_ENABLE_RST;
      ctrl_reg.clock_out_stop_bit <= pds_pkg::CLOCK_OUT_STOP_RST;
      ctrl_reg.high_module_stop_bits <= pds_pkg::HIGH_STOP_RST;
      ctrl_reg.low_module_stop_bits <= pds_pkg::LOW_STOP_RST;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Register read data, one cycle after the strobe
  always_comb begin
    rdata_next = pds_pkg::UNMAPPED_READ_VALUE;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        pds_pkg::SYSTEM_CONTROL_REG_ADDR: rdata_next = sys_rd;
        pds_pkg::MODULE_STOP_CTRL_HIGH_ADDR: rdata_next = high_rd;
        pds_pkg::MODULE_STOP_CTRL_LOW_ADDR: rdata_next = ctrl_reg.low_module_stop_bits;
        pds_pkg::STATUS_REG_ADDR: rdata_next = stat_rd;
        default: rdata_next = pds_pkg::UNMAPPED_READ_VALUE;
      endcase
    end
  end

  // Halted module answers ff; its own read data is not looked at
  assign per_rdata_next = sel_stopped ? pds_pkg::HALTED_READ_VALUE : PER_RDATA_I; // [R13]

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      rdata_reg <= pds_pkg::UNMAPPED_READ_VALUE;
      per_rdata_reg <= pds_pkg::UNMAPPED_READ_VALUE;
    end else begin
      rdata_reg <= rdata_next;
      per_rdata_reg <= per_rdata_next;
    end
  end

  // Mode pins are taken on the clock edge that ends reset handling; the board keeps them still
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      mode_reg <= 3'h0;
    end else if (state_reg == pds_pkg::ST_RST_EXC) begin
      mode_reg <= OPERATING_MODE_PINS_I; // [R5]
    end
  end

  // Half-rate replica of the system clock; a flop keeps the pin glitch free
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      clk_phase_reg <= 1'b1;
    end else if (SW_STANDBY_I) begin
      clk_phase_reg <= 1'b1; // [R21]
    end else begin
      clk_phase_reg <= ~clk_phase_reg; // [R20]
    end
  end

  assign REG_RDATA_O = rdata_reg;
  assign PER_RDATA_O = per_rdata_reg;
  assign HW_STANDBY_O = hw_standby; // [R1]
  assign CPU_HALT_O = hw_standby | (state_reg == pds_pkg::ST_OSC_WAIT); // [R1]
  assign OSC_RUN_O = ~hw_standby; // [R6]
  assign RESET_EXC_O = (state_reg == pds_pkg::ST_RST_EXC); // [R8]
  assign PROGRAM_RUN_O = (state_reg == pds_pkg::ST_RUN) & ~standby_pin_low; // [R8]
  assign RAM_ENABLE_O = ctrl_reg.ram_enable_bit;
  assign PORT_HIZ_O = hw_standby; // [R3]
  assign MODE_O = mode_reg;
  assign MODULE_RESET_O = stop_vec | {NUM_MODULES{hw_standby}}; // [R2] [R12] [R15]
  assign MODULE_PIN_FUNC_EN_O = ~MODULE_RESET_O; // [R17]
  assign PER_WR_O = PER_REQ_I.wr & ~sel_stopped & ~hw_standby; // [R14]
  assign PER_RD_O = PER_REQ_I.rd & ~sel_stopped & ~hw_standby; // [R13]
  assign SYS_CLK_PIN_O = clk_phase_reg;
  assign SYS_CLK_PIN_OE_N_O = hw_standby | ctrl_reg.clock_out_stop_bit; // [R19] [R21]

  // Checks
  property p_standby_now;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      standby_pin_low |-> (HW_STANDBY_O && CPU_HALT_O && !PROGRAM_RUN_O);
  endproperty
  a_standby_now: assert property (p_standby_now) else $error("standby not immediate"); // [R1]

  property p_all_reset;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      standby_pin_low |=> (&MODULE_RESET_O) && ctrl_reg.ram_enable_bit;
  endproperty
  a_all_reset: assert property (p_all_reset) else $error("modules not reset"); // [R2]

  property p_port_hiz;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      hw_standby |-> PORT_HIZ_O && SYS_CLK_PIN_OE_N_O;
  endproperty
  a_port_hiz: assert property (p_port_hiz) else $error("ports driven in standby"); // [R3]

  property p_osc_start;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      (state_reg == pds_pkg::ST_HW_STANDBY) && HW_STANDBY_PIN_N_I && !CHIP_RESET_PIN_N_I
      |=> (OSC_RUN_O || standby_pin_low) && (state_reg == pds_pkg::ST_OSC_WAIT);
  endproperty
  a_osc_start: assert property (p_osc_start) else $error("oscillator not restarted"); // [R6]

  sequence s_reset_pin_rise;
    (state_reg == pds_pkg::ST_OSC_WAIT) && CHIP_RESET_PIN_N_I && HW_STANDBY_PIN_N_I;
  endsequence
  sequence s_exc_then_run;
    RESET_EXC_O ##1 (PROGRAM_RUN_O || !HW_STANDBY_PIN_N_I);
  endsequence
  property p_reset_exc;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      s_reset_pin_rise |=> s_exc_then_run;
  endproperty
  a_reset_exc: assert property (p_reset_exc) else $error("no reset handling"); // [R8]

  property p_stop_next;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      wr_low && !hw_standby && REG_WDATA_I[0] |=> MODULE_RESET_O[0] && !MODULE_PIN_FUNC_EN_O[0];
  endproperty
  a_stop_next: assert property (p_stop_next) else $error("module not halted"); // [R12] [R17]

  property p_ff_read;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      sel_stopped |=> PER_RDATA_O == pds_pkg::HALTED_READ_VALUE;
  endproperty
  a_ff_read: assert property (p_ff_read) else $error("halted read not ff"); // [R13]

  property p_wr_drop;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      sel_stopped |-> !PER_WR_O && !PER_RD_O;
  endproperty
  a_wr_drop: assert property (p_wr_drop) else $error("write reached halted module"); // [R14]

  property p_mod_reset;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      $rose(stop_vec[NUM_MODULES-1]) |-> MODULE_RESET_O[NUM_MODULES-1];
  endproperty
  a_mod_reset: assert property (p_mod_reset) else $error("halted module not reset"); // [R15]

  property p_clk_hiz;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      ctrl_reg.clock_out_stop_bit |-> SYS_CLK_PIN_OE_N_O;
  endproperty
  a_clk_hiz: assert property (p_clk_hiz) else $error("clock pin driven while stopped"); // [R19]

  property p_clk_run;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      !$past(RESET_I) && !ctrl_reg.clock_out_stop_bit && !hw_standby && !SW_STANDBY_I &&
      !$past(SW_STANDBY_I)
      |-> !SYS_CLK_PIN_OE_N_O && (SYS_CLK_PIN_O != $past(SYS_CLK_PIN_O));
  endproperty
  a_clk_run: assert property (p_clk_run) else $error("clock not toggling"); // [R20]

  property p_clk_high;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      SW_STANDBY_I ##1 SW_STANDBY_I |-> SYS_CLK_PIN_O;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("clock not high in sw standby"); // [R21]

  // Sleep keeps the clock pin driven just as in normal operation
  property p_clk_sleep;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      SLEEP_I && !ctrl_reg.clock_out_stop_bit && !hw_standby |-> !SYS_CLK_PIN_OE_N_O;
  endproperty
  a_clk_sleep: assert property (p_clk_sleep) else $error("clock pin off in sleep"); // [R20]

endmodule // pds_top

// File: shared/pds_pkg.sv
package pds_pkg;
  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_HIGH_STOP = 3;
  localparam int NUM_LOW_STOP = 8;
  localparam int NUM_MODULES = NUM_HIGH_STOP + NUM_LOW_STOP;
  localparam int SEL_W = 4;
  localparam int MODE_W = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] SYSTEM_CONTROL_REG_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] MODULE_STOP_CTRL_HIGH_ADDR = 4'h1;
  localparam logic [ADDR_W-1:0] MODULE_STOP_CTRL_LOW_ADDR = 4'h2;
  localparam logic [ADDR_W-1:0] STATUS_REG_ADDR = 4'h3;

  // Field positions
  localparam int RAM_ENABLE_BIT_POS = 0;
  localparam int CLOCK_OUT_STOP_BIT_POS = 7;

  // Reset values
  localparam logic RAM_ENABLE_RST = 1'b1;
  localparam logic CLOCK_OUT_STOP_RST = 1'b0;
  localparam logic [NUM_HIGH_STOP-1:0] HIGH_STOP_RST = 3'h0;
  localparam logic [NUM_LOW_STOP-1:0] LOW_STOP_RST = 8'h0;

  // Values returned by a halted module and by an unmapped or idle register read
  localparam logic [DATA_W-1:0] HALTED_READ_VALUE = 8'hff;
  localparam logic [DATA_W-1:0] UNMAPPED_READ_VALUE = 8'h00;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HW_STANDBY,
    ST_OSC_WAIT,
    ST_RST_EXC
  } pds_state_t;

  typedef struct packed {
    logic clock_out_stop_bit;
    logic [NUM_HIGH_STOP-1:0] high_module_stop_bits;
    logic [NUM_LOW_STOP-1:0] low_module_stop_bits;
    logic ram_enable_bit;
  } pds_ctrl_t;

  // Access from the CPU toward one supporting module
  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic wr;
    logic rd;
  } pds_per_req_t;
endpackage

// File: tb/pds_board.sv
`timescale 1ns/1ps
module pds_board (
  // Board clock reference
  input wire logic clk_i,
  // Pins toward the device
  output logic standby_n_o,
  output logic chip_reset_n_o,
  output logic [pds_pkg::MODE_W-1:0] mode_o
);
  // Mode pins never move once set
  initial begin
    standby_n_o = 1'b1;
    chip_reset_n_o = 1'b1;
    mode_o = 3'h5;
  end
  // Reset pin falls before the standby pin
  task automatic enter();
    @(posedge clk_i);
    chip_reset_n_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    standby_n_o <= 1'b0;
  endtask
  // Standby pin rises first, reset stays low meanwhile
  task automatic wake();
    @(posedge clk_i);
    standby_n_o <= 1'b1;
  endtask
  // Caller waits out the oscillator settling before this
  task automatic release_rst();
    @(posedge clk_i);
    chip_reset_n_o <= 1'b1;
  endtask
endmodule // pds_board

// File: tb/tb_power_down_standby_control.sv
`timescale 1ns/1ps
module tb_power_down_standby_control;
  localparam int NM = pds_pkg::NUM_MODULES;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sw_standby = 1'b0;
  logic sleep = 1'b0;
  pds_pkg::pds_per_req_t preq = '0;
  logic [7:0] prdata = 8'h00;
  logic standby_n, chip_reset_n, hw_standby, halt, osc, rexc, prun, ram_en, hiz;
  logic per_wr, per_rd, ck, ck_oe_n;
  logic [2:0] mode, mode_o;
  logic [7:0] rdata, per_rdata;
  logic [NM-1:0] mrst, pfen, stop;
  int n_mismatch = 0;
  int checks = 0;
  int seed = 69129;
  logic [7:0] exp_q[$];
  logic rd_q = 1'b0;
  logic prd_q = 1'b0;

  always #2 clk = ~clk;

  pds_top #(.NUM_MODULES(NM)) pds_top_inst (
    .CLK_SYS_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .HW_STANDBY_PIN_N_I(standby_n),
    .CHIP_RESET_PIN_N_I(chip_reset_n), .OPERATING_MODE_PINS_I(mode),
    .SW_STANDBY_I(sw_standby),
    .SLEEP_I(sleep), .HW_STANDBY_O(hw_standby), .CPU_HALT_O(halt), .OSC_RUN_O(osc),
    .RESET_EXC_O(rexc), .PROGRAM_RUN_O(prun), .RAM_ENABLE_O(ram_en), .PORT_HIZ_O(hiz),
    .MODE_O(mode_o), .MODULE_RESET_O(mrst), .MODULE_PIN_FUNC_EN_O(pfen), .PER_REQ_I(preq),
    .PER_RDATA_I(prdata), .PER_WR_O(per_wr), .PER_RD_O(per_rd), .PER_RDATA_O(per_rdata),
    .SYS_CLK_PIN_O(ck), .SYS_CLK_PIN_OE_N_O(ck_oe_n)
  );
  pds_board pds_board_inst (.clk_i(clk), .standby_n_o(standby_n),
    .chip_reset_n_o(chip_reset_n), .mode_o(mode));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Expected read data is queued; the watcher below compares it
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic pacc(input int m, input logic w);
    logic [7:0] v;
    v = 8'($random(seed));
    @(posedge clk);
    preq <= '{sel: m[3:0], wr: w, rd: !w};
    prdata <= v;
    #1 chk("per wr", w && !stop[m], per_wr);
    chk("per rd", !w && !stop[m], per_rd);
    if (!w) exp_q.push_back(stop[m] ? 8'hff : v);
    @(posedge clk);
    preq <= '0;
  endtask

  // Read data stands only in the cycle after the strobe, so look mid-cycle
  always @(posedge clk) begin
    rd_q <= rd;
    prd_q <= preq.rd;
  end
  always @(negedge clk) begin
    if (rd_q) chk("reg rdata", exp_q.pop_front(), rdata);
    if (prd_q) chk("per rdata", exp_q.pop_front(), per_rdata);
  end

  initial begin
    #20000;
    n_mismatch++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    logic v;
    bit seen;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rreg(4'h0, 8'h01);
    rreg(4'h1, 8'h00);
    rreg(4'h2, 8'h00);
    rreg(4'h3, 8'h0d);
    rreg(4'h9, 8'h00);
    #1 chk("clk oe_n", 1'b0, ck_oe_n);
    $display("test reset values done");

    // No module interrupt is enabled here before a stop bit is set
    for (int i = 0; i < 6; i++) begin
      stop = (i == 0) ? '1 : NM'($random(seed));
      wreg(4'h1, {5'h00, stop[10:8]});
      wreg(4'h2, stop[7:0]);
      #1 chk("module reset", stop, mrst);
      chk("pin func", NM'(~stop), pfen);
      rreg(4'h1, {5'h00, stop[10:8]});
      for (int m = 0; m < NM; m++) pacc(m, m[0]);
    end
    // Stop bits cleared first, then the module is set up again
    stop = '0;
    wreg(4'h1, 8'h00);
    wreg(4'h2, 8'h00);
    pacc(4, 1'b1);
    pacc(4, 1'b0);
    $display("test module standby done");

    wreg(4'h1, 8'h80);
    #1 chk("clk oe_n", 1'b1, ck_oe_n);
    wreg(4'h1, 8'h00);
    for (int k = 0; k < 2; k++) begin
      sleep <= k[0];
      repeat (2) @(posedge clk);
      #1 v = ck;
      @(posedge clk);
      #1 chk("clk toggle", !v, ck);
      chk("clk oe_n", 1'b0, ck_oe_n);
    end
    sw_standby <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("clk high", 1'b1, ck);
    chk("clk oe_n", 1'b0, ck_oe_n);
    sw_standby <= 1'b0;
    sleep <= 1'b0;
    $display("test clock pin done");

    wreg(4'h2, 8'h0f);
    wreg(4'h0, 8'h00);
    #1 chk("ram enable", 1'b0, ram_en);
    pds_board_inst.enter();
    #1 chk("hw standby", 1'b1, hw_standby);
    chk("halt", 1'b1, halt);
    chk("port hiz", 1'b1, hiz);
    chk("module reset", {NM{1'b1}}, mrst);
    chk("clk oe_n", 1'b1, ck_oe_n);
    wreg(4'h2, 8'h33);
    rreg(4'h2, 8'h00);
    rreg(4'h3, 8'h02);
    pds_board_inst.wake();
    @(posedge clk);
    #1 chk("osc run", 1'b1, osc);
    chk("halt", 1'b1, halt);
    pds_board_inst.enter();
    #1 chk("hw standby", 1'b1, hw_standby);
    chk("osc run", 1'b0, osc);
    pds_board_inst.wake();
    repeat (4) @(posedge clk);
    pds_board_inst.release_rst();
    seen = 0;
    for (int k = 0; k < 8 && !seen; k++) begin
      @(posedge clk);
      #1 seen = (rexc === 1'b1);
    end
    chk("reset exc", 1'b1, seen);
    @(posedge clk);
    #1 chk("reset exc pulse", 1'b0, rexc);
    chk("prog run", 1'b1, prun);
    chk("mode", 3'h5, mode_o);
    chk("ram enable", 1'b1, ram_en);
    rreg(4'h0, 8'h01);
    rreg(4'h2, 8'h00);
    repeat (2) @(posedge clk);
    $display("test hardware standby done");
    end_sim();
  end
endmodule // tb_power_down_standby_control
